// ---- link_serializer_model.sv ----
/*
 Behavioural serializer feeding the decoder's recovered-bit pins.
 Assumes callers start a word just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module link_serializer_model (
	// Clock
	input wire logic clock,
	// Link pins toward the decoder
	output logic serial_bit,
	output logic bit_toggle
);
	// Quiet link at start
	initial begin
		serial_bit = 1'b0;
		bit_toggle = 1'b0;
	end
	// Bit zero first, data settled two clocks before its toggle
	task automatic send_word(input logic [19:0] w);
		for (int i = 0; i < 20; i++) begin
			serial_bit <= w[i];
			repeat (2) @(posedge clock);
			bit_toggle <= ~bit_toggle;
			repeat (2) @(posedge clock);
		end
		serial_bit <= ~w[19]; // Idle line shows no stale bit
	endtask : send_word
endmodule : link_serializer_model
`default_nettype wire

// ---- tb_video_link_word_decoder.sv ----
/*
 Self-checking bench: serializer model drives words, outputs are compared.
 Assumes the decoder, its package and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_video_link_word_decoder;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic sleep_n = 1'b1;
	logic output_drive_on = 1'b1;
	logic latch_rising = 1'b1;
	logic spread_wide = 1'b0;
	logic ref_clk = 1'b0;
	logic serial_bit, bit_toggle;
	logic [17:0] video_word_out;
	logic [8:0] control_word_out;
	logic video_phase_flag, pclk_out, sync_n, data_oe_n, sync_oe_n;
	logic word_fifo_ready;
	logic [17:0] exp_v;
	logic [8:0] exp_c;
	int n_mismatch = 0;
	int tests_run = 0;
	logic [19:0] words [4];
	// Clock and slower reference clock
	always #5 clock = ~clock;
	always @(posedge clock) ref_clk <= ~ref_clk;
	video_link_word_decoder #(.SEARCH_LIMIT(16)) dut (
		.clock(clock), .resetn(resetn), .serial_bit(serial_bit),
		.bit_toggle(bit_toggle), .local_reference_clock(ref_clk),
		.sleep_n(sleep_n), .output_drive_on(output_drive_on),
		.latch_rising(latch_rising), .spread_wide(spread_wide),
		.video_word_out(video_word_out), .control_word_out(control_word_out),
		.video_phase_flag(video_phase_flag), .pclk_out(pclk_out),
		.sync_n(sync_n), .data_oe_n(data_oe_n), .sync_oe_n(sync_oe_n),
		.word_fifo_ready(word_fifo_ready)
	);
	link_serializer_model ser (
		.clock(clock), .serial_bit(serial_bit), .bit_toggle(bit_toggle)
	);
	logic pclk_q = 1'b0;
	logic [17:0] cap_v = 18'h00000;
	// Downstream latch on the parallel clock edge picked by latch_rising
	always @(posedge clock) begin
		pclk_q <= pclk_out;
		if (pclk_out != pclk_q && pclk_out == latch_rising) begin
			cap_v <= video_word_out;
		end
	end
	// Control word with one corrupted copy in each tripled bit
	function automatic logic [19:0] ctl_enc(input logic [8:0] c, input int k);
		logic [19:0] w;
		w = 20'h00000;
		for (int i = 0; i < 5; i++) begin
			w[3*i+1+:3] = {3{c[i]}};
			w[3*i+1+((i+k)%3)] = ~c[i];
		end
		w[19:16] = c[8:5];
		return w;
	endfunction : ctl_enc
	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("mismatch %0t %s", $time, msg);
		end
	endtask : check
	task automatic results();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	// Bounded wait for lock
	task automatic wait_sync();
		for (int i = 0; i < 200 && sync_n !== 1'b0; i++) @(posedge clock);
		if (sync_n !== 1'b0) begin
			n_mismatch++;
			$display("mismatch %0t sync timeout", $time);
			results();
		end
	endtask : wait_sync
	// Send one word and compare both output groups and the flag
	task automatic push(input logic [19:0] w);
		ser.send_word(w);
		if (w[0]) begin
			exp_v = w[1] ? ~w[19:2] : w[19:2];
		end else begin
			for (int i = 0; i < 5; i++) begin
				exp_c[i] = (w[3*i+1] & w[3*i+2]) | (w[3*i+1] & w[3*i+3])
					| (w[3*i+2] & w[3*i+3]);
			end
			exp_c[8:5] = w[19:16];
		end
		repeat (16) @(posedge clock);
		check(cap_v === exp_v, "latched video");
		check(video_word_out === exp_v, "video word");
		check(control_word_out === exp_c, "control word");
		check(video_phase_flag === w[0], "phase flag");
		check(sync_n === 1'b0, "sync lost");
	endtask : push
	initial begin
		exp_v = 18'h00000;
		exp_c = 9'h000;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		repeat (10) @(posedge clock);
		check(sync_n === 1'b1 && video_word_out === 18'h00000, "idle");
		ser.send_word(video_link_pkg::TRANSITION_WORD);
		wait_sync();
		words = '{ctl_enc(9'h1A5, 0), {18'h2D3C1, 2'h1},
			{18'h0F0F0, 2'h3}, ctl_enc(9'h05A, 1)};
		foreach (words[i]) push(words[i]);
		spread_wide <= 1'b1;
		push(ctl_enc(9'h1FF, 2));
		check(word_fifo_ready === 1'b1, "buffer full");
		// Output enable off keeps the sync indicator driven
		output_drive_on <= 1'b0;
		repeat (8) @(posedge clock);
		check(data_oe_n === 1'b1 && sync_oe_n === 1'b0, "drive off");
		output_drive_on <= 1'b1;
		repeat (8) @(posedge clock);
		check(data_oe_n === 1'b0, "drive on");
		// Silent link drops sync and clears outputs
		repeat (150) @(posedge clock);
		check(sync_n === 1'b1 && video_word_out === 18'h00000, "loss");
		check(control_word_out === 9'h000 && !video_phase_flag, "loss ctl");
		// Sleep floats everything and stops the clock
		sleep_n <= 1'b0;
		repeat (10) @(posedge clock);
		check(sync_oe_n === 1'b1 && data_oe_n === 1'b1, "sleep oe");
		check(pclk_out === 1'b0 && sync_n === 1'b1, "sleep out");
		// Wake with capture on the falling parallel clock edge
		sleep_n <= 1'b1;
		latch_rising <= 1'b0;
		repeat (10) @(posedge clock);
		ser.send_word(video_link_pkg::TRANSITION_WORD);
		wait_sync();
		exp_c = 9'h000;
		push({18'h3FFFE, 2'h1});
		results();
	end
endmodule : tb_video_link_word_decoder
`default_nettype wire

// ---- video_link_pkg.sv ----
/*
 Shared constants, types and helpers for the serial video word decoder.
 Assumes a single 100 MHz system clock; no other dependencies.
*/
`default_nettype none
package video_link_pkg;
	// Word layout
	localparam int WORD_BITS = 20;
	localparam int OH0_POS = 0;
	localparam int OH1_POS = 1;
	localparam int SYM_LSB = 2;
	localparam int SYM_COUNT = 18;
	localparam int CTL_LSB = 1;
	localparam int CTL_VOTED = 5;
	localparam int CTL_COPIES = 3;
	localparam int CTL_SINGLE_LSB = 16;
	localparam int CTL_COUNT = 9;
	// Default alignment pattern, first bit in bit 0
	localparam logic [19:0] TRANSITION_WORD = 20'h003FF;
	// Clocking
	localparam int CLOCK_MHZ = 100;
	localparam int WORD_MHZ_MIN = 5;
	localparam int WORD_MHZ_MAX = 42;
	localparam int WORD_MHZ_DEFAULT = 25;
	localparam int OUT_DIV = CLOCK_MHZ / WORD_MHZ_DEFAULT;
	localparam int OUT_DIV_MIN = (CLOCK_MHZ + WORD_MHZ_MAX - 1) / WORD_MHZ_MAX;
	localparam int OUT_DIV_MAX = CLOCK_MHZ / WORD_MHZ_MIN;
	// Search limit in recovered word clocks
	localparam int SEARCH_LIMIT_LOG2 = 22;
	localparam int SEARCH_LIMIT = 2 ** SEARCH_LIMIT_LOG2;
	// Spread amounts in percent, modulation half period in words
	localparam logic [6:0] SPREAD_WIDE_PCT = 7'h04;
	localparam logic [6:0] SPREAD_NARROW_PCT = 7'h02;
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam int SPREAD_HALF_WORDS = 512;
	// Buffer
	localparam int FIFO_DEPTH = 32;
	localparam int PIN_COUNT = 6;

	// One decoded word on its way to the outputs
	typedef struct packed {
		logic video;
		logic [SYM_COUNT-1:0] payload;
	} dec_word_s;

	typedef enum logic [1:0] {
		ST_SLEEP = 2'h0,
		ST_SEARCH = 2'h1,
		ST_SYNCED = 2'h3
	} link_state_e;

	// Two or three equal copies decide the bit
	function automatic logic majority3(input logic [2:0] c);
		majority3 = (c[0] & c[1]) | (c[0] & c[2]) | (c[1] & c[2]);
	endfunction : majority3
endpackage : video_link_pkg
`default_nettype wire

// ---- video_link_word_decoder.sv ----
/*
 Receive-side word decoder: frames serial words, decodes video and
 control phases, buffers them and paces them out with a parallel clock.
 Assumes bit recovery outside: one serial data pin and one pin that
 toggles once per received bit, both asynchronous to the clock.
*/
// How it works
// - Words are 20 bits, bit zero first
// - Video: two overhead bits, then 18 symbols
// - Control: overhead, five tripled bits, four singles
// - Video uses two overhead bits, control one
// - Tripled control bits decided by majority vote
// - Single control bits pass through unvoted
// - Phase flag high for video, low control
// - Control outputs change only in control phase
// - Video outputs change only in video phase
// - Sync low only while outputs are valid
// - Output enable low floats outputs except sync
// - Spread select picks four or two percent
// - Word clock between 5 and 42 MHz
// - Transition word found: sync low, recovered clock
// - Search timeout: sync high, outputs low, reference
// - Outputs change opposite to the capture edge
`timescale 1ns/1ps
`default_nettype none
module video_link_word_decoder #(
	parameter int SEARCH_LIMIT = video_link_pkg::SEARCH_LIMIT,
	parameter int DIVIDER = video_link_pkg::OUT_DIV,
	parameter int DEPTH = video_link_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Serial link after bit recovery, and the local reference clock
	input wire logic serial_bit,
	input wire logic bit_toggle,
	input wire logic local_reference_clock,
	// Control pins
	input wire logic sleep_n,
	input wire logic output_drive_on,
	input wire logic latch_rising,
	input wire logic spread_wide,
	// Parallel outputs
	output logic [17:0] video_word_out,
	output logic [8:0] control_word_out,
	output logic video_phase_flag,
	output logic pclk_out,
	output logic sync_n,
	// Output enables, low while driving
	output logic data_oe_n,
	output logic sync_oe_n,
	// Buffer status
	output logic word_fifo_ready
);
	localparam int CNT_W = $clog2(SEARCH_LIMIT) + 1;
	localparam int DIV_W = $clog2(video_link_pkg::OUT_DIV_MAX + 2);
	localparam int SPW = $clog2(video_link_pkg::SPREAD_HALF_WORDS);
	localparam int DW = $bits(video_link_pkg::dec_word_s);
	localparam logic [DIV_W-1:0] DIV_BASE = DIV_W'(DIVIDER);
	localparam logic [CNT_W-1:0] LIMIT_LAST = CNT_W'(SEARCH_LIMIT - 1);
	localparam logic [SPW-1:0] SPREAD_LAST =
		SPW'(video_link_pkg::SPREAD_HALF_WORDS - 1);

	// Reset release and pin synchronisers
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [video_link_pkg::PIN_COUNT-1:0] pin_meta_reg;
	logic [video_link_pkg::PIN_COUNT-1:0] pin_sync_reg;
	logic bit_s, toggle_s, ref_s, awake_s, drive_s, rising_s;
	logic toggle_prev_reg;
	logic bit_strobe;

	// Link state
	video_link_pkg::link_state_e state_reg;
	logic synced;
	logic searching;
	logic [CNT_W-1:0] wait_cnt_reg;
	logic timeout;

	// Framing and buffering
	logic word_valid;
	logic [19:0] word;
	logic found;
	video_link_pkg::dec_word_s dec_word;
	video_link_pkg::dec_word_s head;
	logic head_valid;
	logic pop;

	// Word clock generation
	logic [DIV_W-1:0] div_cnt_reg;
	logic [DIV_W-1:0] div_len_reg;
	logic [DIV_W-1:0] div_len_next;
	logic [6:0] spread_acc_reg;
	logic [6:0] spread_sum;
	logic [6:0] spread_pct;
	logic spread_dir_reg;
	logic [SPW-1:0] spread_words_reg;
	logic rise_point, fall_point, word_tick, update_en;
	logic pclk_reg;

	// Splits a received word by its phase
	function automatic video_link_pkg::dec_word_s decode_word(
		input logic [19:0] w);
		video_link_pkg::dec_word_s d;
		d = '0;
		d.video = w[video_link_pkg::OH0_POS];
		if (d.video) begin
			// Second overhead bit marks inverted symbols
			d.payload = w[video_link_pkg::SYM_LSB +:
				video_link_pkg::SYM_COUNT];
			if (w[video_link_pkg::OH1_POS]) begin
				d.payload = ~d.payload;
			end
		end else begin
			for (int i = 0; i < video_link_pkg::CTL_VOTED; i++) begin
				d.payload[i] = video_link_pkg::majority3(
					w[video_link_pkg::CTL_LSB +
					i * video_link_pkg::CTL_COPIES +:
					video_link_pkg::CTL_COPIES]);
			end
			d.payload[video_link_pkg::CTL_COUNT-1:video_link_pkg::CTL_VOTED]
				= w[19:video_link_pkg::CTL_SINGLE_LSB];
		end
		return d;
	endfunction : decode_word

	// Reset release through two flops
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Two-flop synchronisers for every pin input except spread_wide
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			pin_meta_reg <= {serial_bit, bit_toggle, local_reference_clock,
				sleep_n, output_drive_on, latch_rising};
			pin_sync_reg <= pin_meta_reg;
		end
	end
	assign {bit_s, toggle_s, ref_s, awake_s, drive_s, rising_s} =
		pin_sync_reg;

	// Bit strobe from the toggling bit timing pin
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			toggle_prev_reg <= 1'b0;
		end else begin
			toggle_prev_reg <= toggle_s;
		end
	end
	assign bit_strobe = awake_s && (toggle_s ^ toggle_prev_reg);

	// Link state: sleep has priority over everything
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= video_link_pkg::ST_SLEEP;
		end else if (!awake_s) begin
			state_reg <= video_link_pkg::ST_SLEEP;
		end else begin
			unique case (state_reg)
				video_link_pkg::ST_SLEEP: begin
					state_reg <= video_link_pkg::ST_SEARCH;
				end
				video_link_pkg::ST_SEARCH: begin
					if (found) begin
						state_reg <= video_link_pkg::ST_SYNCED;
					end
				end
				video_link_pkg::ST_SYNCED: begin
					if (timeout) begin
						state_reg <= video_link_pkg::ST_SEARCH;
					end
				end
				default: begin
					state_reg <= video_link_pkg::ST_SLEEP;
				end
			endcase
		end
	end
	assign synced = (state_reg == video_link_pkg::ST_SYNCED);
	assign searching = (state_reg == video_link_pkg::ST_SEARCH);

	// Word clocks spent searching, or since the last bit when synced
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt_reg <= '0;
		end else if (!awake_s || found || (synced && bit_strobe)) begin
			wait_cnt_reg <= '0;
		end else if (word_tick) begin
			wait_cnt_reg <= timeout ? '0 : wait_cnt_reg + 1'b1;
		end
	end
	assign timeout = word_tick && (wait_cnt_reg == LIMIT_LAST);

	// Framing of serial words
	word_deframer #(
		.WIDTH(video_link_pkg::WORD_BITS),
		.PATTERN(video_link_pkg::TRANSITION_WORD)
	) deframer (
		.clock(clock),
		.rst_n(rst_n),
		.bit_strobe(bit_strobe),
		.bit_value(bit_s),
		.search(!synced),
		.word_valid(word_valid),
		.word(word),
		.found(found)
	);

	assign dec_word = decode_word(word);

	// Decoded words wait here for their output slot
	word_fifo #(
		.WIDTH(DW),
		.DEPTH(DEPTH)
	) buffer (
		.clock(clock),
		.rst_n(rst_n),
		.flush(!synced),
		.in_valid(word_valid && synced),
		.in_ready(word_fifo_ready),
		.in_data(dec_word),
		.out_valid(head_valid),
		.out_ready(pop),
		.out_data(head)
	);

	// Spread amount from the select input
	assign spread_pct = spread_wide ? video_link_pkg::SPREAD_WIDE_PCT
		: video_link_pkg::SPREAD_NARROW_PCT;
	assign spread_sum = spread_acc_reg + spread_pct;

	// Word period, stretched or shrunk by one clock as spread demands
	always_comb begin
		div_len_next = DIV_BASE;
		if (spread_sum >= video_link_pkg::PCT_FULL) begin
			div_len_next = spread_dir_reg ? DIV_BASE + 1'b1
				: DIV_BASE - 1'b1;
		end
	end

	// Word clock divider
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_reg <= '0;
			div_len_reg <= DIV_BASE;
		end else if (!awake_s) begin
			div_cnt_reg <= '0;
			div_len_reg <= DIV_BASE;
		end else if (word_tick) begin
			div_cnt_reg <= '0;
			div_len_reg <= div_len_next;
		end else begin
			div_cnt_reg <= div_cnt_reg + 1'b1;
		end
	end
	assign word_tick = (div_cnt_reg == div_len_reg - 1'b1);
	assign rise_point = (div_cnt_reg == '0);
	assign fall_point = (div_cnt_reg == (div_len_reg >> 1));

	// Triangle modulation of the spread
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			spread_acc_reg <= '0;
			spread_dir_reg <= 1'b0;
			spread_words_reg <= '0;
		end else if (word_tick) begin
			spread_acc_reg <= (spread_sum >= video_link_pkg::PCT_FULL)
				? spread_sum - video_link_pkg::PCT_FULL : spread_sum;
			spread_words_reg <= spread_words_reg + 1'b1;
			if (spread_words_reg == SPREAD_LAST) begin
				spread_dir_reg <= !spread_dir_reg;
			end
		end
	end

	// Recovered clock, high in the first half of the word period
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pclk_reg <= 1'b0;
		end else if (rise_point) begin
			pclk_reg <= 1'b1;
		end else if (fall_point) begin
			pclk_reg <= 1'b0;
		end
	end

	// Data moves half a period away from the capture edge
	assign update_en = rising_s ? fall_point : rise_point;
	assign pop = synced && update_en && head_valid;

	// Clock output: reference until synced, then recovered
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pclk_out <= 1'b0;
		end else if (!awake_s) begin
			pclk_out <= 1'b0;
		end else begin
			pclk_out <= synced ? pclk_reg : ref_s;
		end
	end

	// Video outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			video_word_out <= '0;
		end else if (!synced) begin
			video_word_out <= '0;
		end else if (pop && head.video) begin
			video_word_out <= head.payload;
		end
	end

	// Control outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			control_word_out <= '0;
		end else if (!synced) begin
			control_word_out <= '0;
		end else if (pop && !head.video) begin
			control_word_out <= head.payload[8:0];
		end
	end

	// Phase flag follows the last word placed on the outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			video_phase_flag <= 1'b0;
		end else if (!synced) begin
			video_phase_flag <= 1'b0;
		end else if (pop) begin
			video_phase_flag <= head.video;
		end
	end

	// Sync indicator, low only while aligned
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_n <= 1'b1;
		end else begin
			sync_n <= !(synced && !timeout && awake_s);
		end
	end

	// Output enables: sync stays driven whatever the enable pin says
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_oe_n <= 1'b1;
			sync_oe_n <= 1'b1;
		end else begin
			data_oe_n <= !(awake_s && drive_s);
			sync_oe_n <= !awake_s;
		end
	end
endmodule : video_link_word_decoder
`default_nettype wire

// ---- video_link_word_decoder_asserts.sv ----
/*
 Port-level checker for the serial video word decoder.
 Assumes one clock and the asynchronous active-low reset of the top.
*/
`timescale 1ns/1ps
`default_nettype none
module video_link_word_decoder_checker #(
	parameter int SEARCH_LIMIT = 16,
	parameter int DIVIDER = 4,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Reference clock and control pins
	input wire logic local_reference_clock,
	input wire logic sleep_n,
	input wire logic output_drive_on,
	// Watched outputs
	input wire logic [17:0] video_word_out,
	input wire logic [8:0] control_word_out,
	input wire logic video_phase_flag,
	input wire logic pclk_out,
	input wire logic sync_n,
	input wire logic data_oe_n,
	input wire logic sync_oe_n
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	// Sleep pin held low long enough to pass its synchronisers
	sequence asleep_s;
		!sleep_n [*5];
	endsequence
	sequence awake_s;
		sleep_n [*8];
	endsequence
	video_hold_a: assert property (
		$changed(video_word_out) && !sync_n |-> video_phase_flag)
		else $error("video outputs moved in control phase");
	ctl_hold_a: assert property (
		$changed(control_word_out) && !sync_n |-> !video_phase_flag)
		else $error("control outputs moved in video phase");
	idle_zero_a: assert property (
		sync_n && $past(sync_n, 3) |-> video_word_out == 18'h00000 &&
		control_word_out == 9'h000 && !video_phase_flag)
		else $error("outputs not low while unsynced");
	sleep_off_a: assert property (
		asleep_s |-> sync_oe_n && data_oe_n && sync_n)
		else $error("outputs active in sleep");
	sleep_clk_a: assert property (
		asleep_s |-> !pclk_out)
		else $error("parallel clock runs in sleep");
	drive_off_a: assert property (
		(!output_drive_on) [*5] |-> data_oe_n)
		else $error("data outputs driven while disabled");
	sync_drive_a: assert property (
		awake_s |-> ##[0:4] !sync_oe_n)
		else $error("sync indicator not driven while awake");
	// Sync may stay low for the three clocks the sleep pin takes to act
	sync_shown_a: assert property (
		!sync_n |-> !sync_oe_n && $past(sleep_n, 3))
		else $error("sync low while floating or asleep");
	// Unsynced and awake: clock output is the reference, three clocks late
	ref_follow_a: assert property (
		sync_n && $past(sync_n) && $past(sleep_n, 3) && $past(resetn, 5)
		|-> pclk_out == $past(local_reference_clock, 3))
		else $error("parallel clock not following reference");
endmodule : video_link_word_decoder_checker
bind video_link_word_decoder video_link_word_decoder_checker #(
	.SEARCH_LIMIT(SEARCH_LIMIT), .DIVIDER(DIVIDER), .DEPTH(DEPTH)
) chk (
	.clock(clock), .resetn(resetn), .sleep_n(sleep_n),
	.local_reference_clock(local_reference_clock),
	.output_drive_on(output_drive_on), .video_word_out(video_word_out),
	.control_word_out(control_word_out),
	.video_phase_flag(video_phase_flag), .pclk_out(pclk_out),
	.sync_n(sync_n), .data_oe_n(data_oe_n), .sync_oe_n(sync_oe_n)
);
`default_nettype wire

// ---- word_deframer.sv ----
/*
 Collects serial bits, LSB first, into words and hunts for the
 alignment pattern while searching. Assumes bit strobes are already
 synchronised to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module word_deframer #(
	parameter int WIDTH = 20,
	parameter logic [19:0] PATTERN = video_link_pkg::TRANSITION_WORD
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Bit input
	input wire logic bit_strobe,
	input wire logic bit_value,
	// Alignment control
	input wire logic search,
	// Word output
	output logic word_valid,
	output logic [WIDTH-1:0] word,
	output logic found
);
	localparam int CW = $clog2(WIDTH);
	localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

	logic [WIDTH-1:0] shift_reg;
	logic [WIDTH-1:0] shift_next;
	logic [CW-1:0] count_reg;
	logic match;

	// First bit ends up in bit 0
	assign shift_next = {bit_value, shift_reg[WIDTH-1:1]};
	assign match = search && bit_strobe && (shift_next == PATTERN);

	// Shifter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= '0;
		end else if (bit_strobe) begin
			shift_reg <= shift_next;
		end
	end

	// Bit position, realigned on a pattern hit
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else if (match) begin
			count_reg <= '0;
		end else if (bit_strobe) begin
			count_reg <= (count_reg == LAST) ? '0 : count_reg + 1'b1;
		end
	end

	// Word and event outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			word <= '0;
			word_valid <= 1'b0;
			found <= 1'b0;
		end else begin
			found <= match;
			word_valid <= 1'b0;
			if (bit_strobe && !search && count_reg == LAST) begin
				word <= shift_next;
				word_valid <= 1'b1;
			end
		end
	end
endmodule : word_deframer
`default_nettype wire

// ---- word_fifo.sv ----
/*
 Synchronous FIFO with valid/ready on both sides and a flush input.
 Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic flush,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic push;
	logic pop;

	// Full when pointers differ only in the wrap bit
	assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
	assign out_valid = (wr_ptr_reg != rd_ptr_reg);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg[AW-1:0]];

	// Storage
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	// Write pointer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
		end else if (flush) begin
			wr_ptr_reg <= '0;
		end else if (push) begin
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
		end
	end

	// Read pointer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_reg <= '0;
		end else if (flush) begin
			rd_ptr_reg <= '0;
		end else if (pop) begin
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule : word_fifo
`default_nettype wire
